// file: include/fifo_map.svh
// Constants for the programmable-flag FIFO and its controller register map
`ifndef FIFO_MAP_SVH
`define FIFO_MAP_SVH

// =====================================================================
// Storage geometry
`define FIFO_DEPTH        64
`define FIFO_DATA_W       9
`define FIFO_OFS_W        8
`define FIFO_OFS_COUNT    4
`define FIFO_OFS_LO_RST   8'h07
`define FIFO_OFS_HI_RST   8'h00

// =====================================================================
// Controller APB register byte offsets
`define CTL_ADDR_CTRL     12'h000
`define CTL_ADDR_STATUS   12'h004
`define CTL_ADDR_CMD      12'h008
`define CTL_ADDR_RDATA    12'h00c

// CTRL fields
`define CTL_CTRL_RESET    0
`define CTL_CTRL_STRAP    1

// STATUS fields
`define CTL_ST_EMPTY_N    0
`define CTL_ST_FULL_N     1
`define CTL_ST_AEMPTY_N   2
`define CTL_ST_AFULL_N    3

// CMD fields: data in [8:0], opcode in [10:9]
`define CTL_CMD_DATA_LSB  0
`define CTL_CMD_OP_LSB    9
`define CTL_CMD_OP_MSB    10

// RDATA fields: data in [8:0], fresh flag in bit 16
`define CTL_RD_VALID      16

`endif

// file: include/fifo_pkg.sv
// Types shared by the FIFO device and its controller
package fifo_pkg;

    // Position in the four-register offset rotation
    typedef enum logic [1:0] {
        OFS_EMPTY_LO,
        OFS_EMPTY_HI,
        OFS_FULL_LO,
        OFS_FULL_HI
    } ofs_sel_t;

    // Controller command opcodes, as written to the CMD register
    typedef enum logic [1:0] {
        OP_FIFO_WRITE = 2'h0,
        OP_OFS_WRITE  = 2'h1,
        OP_FIFO_READ  = 2'h2,
        OP_OFS_READ   = 2'h3
    } op_t;

endpackage

// file: include/fifo_pins_if.sv
// Pin bundle between the FIFO device and the controller that drives it
`timescale 1ns/100ps
`include "fifo_map.svh"

interface fifo_pins_if;
    logic [`FIFO_DATA_W-1:0] data_in;                   // Write data / offset data
    logic [`FIFO_DATA_W-1:0] data_out;                  // Read data / offset readback
    logic                    primary_write_gate_n;      // Write enable, active low
    logic                    second_write_gate_or_load; // Write enable 2 or load, mode strap
    logic                    read_gate_a_n;             // Read enable A, active low
    logic                    read_gate_b_n;             // Read enable B, active low
    logic                    reset_n;                   // Device reset, active low
    logic                    empty_flag_n;              // Low when empty
    logic                    full_flag_n;               // Low when full
    logic                    almost_empty_n;            // Low at n or fewer words
    logic                    almost_full_n;             // Low at depth-m or more words

    modport device (
        input  data_in, primary_write_gate_n, second_write_gate_or_load,
        input  read_gate_a_n, read_gate_b_n, reset_n,
        output data_out, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n
    );

    modport ctrl (
        output data_in, primary_write_gate_n, second_write_gate_or_load,
        output read_gate_a_n, read_gate_b_n, reset_n,
        input  data_out, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n
    );
endinterface

// file: logic/fifo_device.sv
// Synchronous 9-bit FIFO with programmable almost-empty / almost-full flags
// Contract
// - Load-mode writes rotate through four offset registers
// - Partial offset writes keep rotation position
// - Load-mode reads rotate offsets onto outputs
// - Controller never mixes offset write and read
// - Almost-empty low at n or fewer words
// - Almost-empty high at n+1 or more
// - Almost-full low at depth-m or more
// - Almost-full high when free exceeds m
// - Offsets default to seven
// - Full flag low at configured depth
// - Writes ignored while full
// - Full flag updates on every clock edge, reads included
// - Empty flag low with no words
// - Reads ignored while empty
// - Empty flag updates on every clock edge, writes included
// - System combines empty and full flags
// - Width expansion: load low at reset
// - Nine-bit words, depth 64 to 8192
// - Pin level at reset selects mode
// - Reset empties FIFO, clears outputs
// - Empty FIFO holds last read word
`timescale 1ns/100ps
`include "fifo_map.svh"

module fifo_device #(
    parameter int DEPTH = `FIFO_DEPTH                    // One of 64 .. 8192
) (
    input  wire logic                     sys_clk_i,     // Read and write clock
    input  wire logic                     rst_i,         // Sync reset, active high
    fifo_pins_if.device                   pins,          // Pins toward the controller
    output logic [$clog2(DEPTH):0]        word_count_o,  // Unread words
    output logic                          prog_mode_o    // High in programmable-flag mode
);

    // =================================================================
    // Sizes and shared helpers
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

    // Joins a low/high offset pair into a threshold; surplus high bits drop
    function automatic logic [CNT_W-1:0] pair_value(
        input logic [`FIFO_OFS_W-1:0] lo,
        input logic [`FIFO_OFS_W-1:0] hi
    );
        pair_value = CNT_W'({hi, lo});
    endfunction

    // =================================================================
    // State
    logic [`FIFO_DATA_W-1:0] mem [DEPTH];
    logic [`FIFO_OFS_W-1:0]  ofs [`FIFO_OFS_COUNT];
    logic [PTR_W-1:0]        wr_ptr, rd_ptr;
    logic [CNT_W-1:0]        count, next_count, thr_n, thr_m;
    fifo_pkg::ofs_sel_t      sel, next_sel;
    logic                    prog_mode, in_reset, load_low, fifo_wr_req, fifo_rd_req;
    logic                    do_wr, do_rd, ofs_wr, ofs_rd;
    logic                    empty_q, full_q, aempty_q, afull_q;
    logic [`FIFO_DATA_W-1:0] dout_q;

    // Either the system reset or the pin reset clears the device
    assign in_reset = rst_i | ~pins.reset_n;

    // =================================================================
    // Request decode
    // In two-enable mode the dual pin is a second active-high write gate;
    // in load mode it must be high for ordinary traffic.
    assign load_low    = prog_mode & ~pins.second_write_gate_or_load;
    assign fifo_wr_req = ~pins.primary_write_gate_n & pins.second_write_gate_or_load;
    assign fifo_rd_req = ~pins.read_gate_a_n & ~pins.read_gate_b_n & ~load_low;
    assign ofs_wr      = load_low & ~pins.primary_write_gate_n;
    assign ofs_rd      = load_low & ~pins.read_gate_a_n & ~pins.read_gate_b_n;
    assign do_wr       = fifo_wr_req & full_q;
    assign do_rd       = fifo_rd_req & empty_q;

    // Thresholds from the programmed pairs
    assign thr_n = pair_value(ofs[fifo_pkg::OFS_EMPTY_LO], ofs[fifo_pkg::OFS_EMPTY_HI]);
    assign thr_m = pair_value(ofs[fifo_pkg::OFS_FULL_LO], ofs[fifo_pkg::OFS_FULL_HI]);

    // Occupancy after this edge; both ports may act in one cycle
    always_comb begin
        next_count = count;
        if (do_wr && !do_rd) begin
            next_count = count + ONE_C;
        end else if (do_rd && !do_wr) begin
            next_count = count - ONE_C;
        end
    end

    // Rotation step; one offset access moves it one place
    assign next_sel = fifo_pkg::ofs_sel_t'(sel + 2'h1);

    // =================================================================
    // Mode strap: caught on every edge while reset is held
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            prog_mode <= ~pins.second_write_gate_or_load;
        end
    end

    // =================================================================
    // Offset registers and rotation position
    // Simultaneous write and read is unsupported; the write wins and the
    // rotation still moves only once.
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            sel                   <= fifo_pkg::OFS_EMPTY_LO;
            ofs <= '{`FIFO_OFS_LO_RST, `FIFO_OFS_HI_RST, `FIFO_OFS_LO_RST, `FIFO_OFS_HI_RST};
        end else if (ofs_wr) begin
            ofs[sel] <= pins.data_in[`FIFO_OFS_W-1:0];
            sel      <= next_sel;
        end else if (ofs_rd) begin
            sel      <= next_sel;
        end
    end

    // =================================================================
    // Storage array, no reset needed on the data itself
    always_ff @(posedge sys_clk_i) begin
        if (do_wr && !in_reset) begin
            mem[wr_ptr] <= pins.data_in;
        end
    end

    // Pointers and occupancy; power-of-two depth wraps them
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            count <= next_count;
        end
    end

    // =================================================================
    // Output register: last valid read stays put when reads are refused
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            dout_q <= '0;
        end else if (do_rd) begin
            dout_q <= mem[rd_ptr];
        end else if (ofs_rd) begin
            dout_q <= {1'b0, ofs[sel]};
        end
    end

    // =================================================================
    // Read-side flags, each one flip-flop on the clock edge
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            empty_q  <= 1'b0;
            aempty_q <= 1'b0;
        end else begin
            empty_q  <= (next_count != '0);
            aempty_q <= (next_count > thr_n);
        end
    end

    // Write-side flags; full compares against the configured depth
    always_ff @(posedge sys_clk_i) begin
        if (in_reset) begin
            full_q  <= 1'b1;
            afull_q <= 1'b1;
        end else begin
            full_q  <= (next_count != DEPTH_C);
            afull_q <= ((DEPTH_C - next_count) > thr_m);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prog_mode_o <= 1'b0;
        end else begin
            prog_mode_o <= prog_mode;
        end
    end

    // Pin outputs, all from flip-flops
    assign pins.data_out       = dout_q;
    assign pins.empty_flag_n   = empty_q;
    assign pins.full_flag_n    = full_q;
    assign pins.almost_empty_n = aempty_q;
    assign pins.almost_full_n  = afull_q;
    assign word_count_o        = count;

endmodule // fifo_device

// file: logic/fifo_ctrl.sv
// APB-controlled writer/reader that drives the FIFO device pins
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "fifo_map.svh"

module fifo_ctrl (
    input  wire logic        sys_clk_i,   // System clock
    input  wire logic        rst_i,       // Sync reset, active high
    input  wire logic        psel_i,      // APB select
    input  wire logic        penable_i,   // APB enable
    input  wire logic        pwrite_i,    // APB direction
    input  wire logic [11:0] paddr_i,     // APB byte address
    input  wire logic [31:0] pwdata_i,    // APB write data
    output logic      [31:0] prdata_o,    // APB read data
    output logic             pready_o,    // APB ready
    output logic             pslverr_o,   // APB error on unmapped address
    fifo_pins_if.ctrl        pins         // Pins toward the device
);

    // =================================================================
    // Bus decode
    logic                    setup, access, wr_ack, mapped, cmd_go;
    logic                    reset_hold, strap, rd_pending, rd_valid;
    logic [`FIFO_DATA_W-1:0] rd_word, cmd_data;
    fifo_pkg::op_t           cmd_op;
    logic [31:0]             next_rdata;

    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i & pready_o;
    assign wr_ack   = access & pwrite_i;
    assign mapped   = (paddr_i == `CTL_ADDR_CTRL) | (paddr_i == `CTL_ADDR_STATUS) |
                      (paddr_i == `CTL_ADDR_CMD)  | (paddr_i == `CTL_ADDR_RDATA);
    assign cmd_go   = wr_ack & (paddr_i == `CTL_ADDR_CMD);
    assign cmd_data = pwdata_i[`CTL_CMD_DATA_LSB +: `FIFO_DATA_W];
    assign cmd_op   = fifo_pkg::op_t'(pwdata_i[`CTL_CMD_OP_MSB:`CTL_CMD_OP_LSB]);

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped;
        end
    end

    // Read mux, captured in the setup cycle so data stands with ready
    always_comb begin
        next_rdata = 32'h0;
        unique case (paddr_i)
            `CTL_ADDR_CTRL: begin
                next_rdata[`CTL_CTRL_RESET] = reset_hold;
                next_rdata[`CTL_CTRL_STRAP] = strap;
            end
            `CTL_ADDR_STATUS: begin
                next_rdata[`CTL_ST_EMPTY_N]  = pins.empty_flag_n;
                next_rdata[`CTL_ST_FULL_N]   = pins.full_flag_n;
                next_rdata[`CTL_ST_AEMPTY_N] = pins.almost_empty_n;
                next_rdata[`CTL_ST_AFULL_N]  = pins.almost_full_n;
            end
            `CTL_ADDR_RDATA: begin
                next_rdata[`FIFO_DATA_W-1:0] = rd_word;
                next_rdata[`CTL_RD_VALID]    = rd_valid;
            end
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0;
        end else if (setup && !pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    // =================================================================
    // Control register: device reset and the mode strap level
    // Reset starts held so the device sees a reset with a known strap.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reset_hold <= 1'b1;
            strap      <= 1'b1;
        end else if (wr_ack && paddr_i == `CTL_ADDR_CTRL) begin
            reset_hold <= pwdata_i[`CTL_CTRL_RESET];
            strap      <= pwdata_i[`CTL_CTRL_STRAP];
        end
    end

    // =================================================================
    // Pin drive: each command is a one-cycle strobe, idle is inactive
    // Outside reset the dual pin rests high, which is both write enable 2 and load off; while reset is held it carries the strap.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pins.reset_n                   <= 1'b0;
            pins.primary_write_gate_n      <= 1'b1;
            pins.second_write_gate_or_load <= 1'b1;
            pins.read_gate_a_n             <= 1'b1;
            pins.read_gate_b_n             <= 1'b1;
            pins.data_in                   <= '0;
        end else begin
            pins.reset_n                   <= ~reset_hold;
            pins.primary_write_gate_n      <= 1'b1;
            pins.second_write_gate_or_load <= reset_hold ? strap : 1'b1;
            pins.read_gate_a_n             <= 1'b1;
            pins.read_gate_b_n             <= 1'b1;
            if (cmd_go && !reset_hold) begin
                pins.data_in <= cmd_data;
                // Only one access per command, never offset write with read
                unique case (cmd_op)
                    fifo_pkg::OP_FIFO_WRITE: pins.primary_write_gate_n <= 1'b0;
                    fifo_pkg::OP_OFS_WRITE: begin
                        pins.primary_write_gate_n      <= 1'b0;
                        pins.second_write_gate_or_load <= 1'b0;
                    end
                    fifo_pkg::OP_FIFO_READ: begin
                        pins.read_gate_a_n <= 1'b0;
                        pins.read_gate_b_n <= 1'b0;
                    end
                    fifo_pkg::OP_OFS_READ: begin
                        pins.read_gate_a_n             <= 1'b0;
                        pins.read_gate_b_n             <= 1'b0;
                        pins.second_write_gate_or_load <= 1'b0;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // Readback: device output settles one edge after the read strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_pending <= 1'b0;
        end else begin
            rd_pending <= ~pins.read_gate_a_n;
        end
    end

    // Fresh flag: a new capture wins over the clear-on-read of RDATA
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_word  <= '0;
            rd_valid <= 1'b0;
        end else if (rd_pending) begin
            rd_word  <= pins.data_out;
            rd_valid <= 1'b1;
        end else if (access && !pwrite_i && paddr_i == `CTL_ADDR_RDATA) begin
            rd_valid <= 1'b0;
        end
    end

endmodule // fifo_ctrl

// file: verification/fifo_pins_asserts.sv
// Pin-level checks between the FIFO device and its controller
`timescale 1ns/100ps
`include "fifo_map.svh"

module fifo_pins_asserts #(
    parameter int DEPTH = `FIFO_DEPTH                 // Same as the device
) (
    input wire logic                    sys_clk_i,    // Clock
    input wire logic                    rst_i,        // Sync reset
    input wire logic [`FIFO_DATA_W-1:0] data_in,      // Write data
    input wire logic [`FIFO_DATA_W-1:0] data_out,     // Read data
    input wire logic                    primary_write_gate_n,      // Write enable
    input wire logic                    second_write_gate_or_load, // Load or enable 2
    input wire logic                    read_gate_a_n, // Read enable A
    input wire logic                    read_gate_b_n, // Read enable B
    input wire logic                    reset_n,      // Device reset
    input wire logic                    empty_flag_n, // Empty flag
    input wire logic                    full_flag_n,  // Full flag
    input wire logic                    almost_empty_n, // Almost empty
    input wire logic                    almost_full_n   // Almost full
);
    localparam int CW = $clog2(DEPTH) + 1;
    logic [CW-1:0] cnt;       // Mirror of unread words
    logic [7:0]    ofs [4];   // Mirror of offset registers
    logic [1:0]    rot;       // Rotation position
    logic          load_mode; // Strap seen while in reset
    logic          dev_rst, ld_lo, wr_ok, rd_ok, ofs_wr, ofs_rd;
    logic [15:0]   n_thr, m_thr;
    logic [8:0]    sel_word;

    // =====================================================================
    // Operations as the pins define them; the count, not the flags, gates them
    assign dev_rst  = rst_i | ~reset_n;
    assign ld_lo    = load_mode & ~second_write_gate_or_load;
    assign ofs_wr   = ld_lo & ~primary_write_gate_n;
    assign ofs_rd   = ld_lo & ~read_gate_a_n & ~read_gate_b_n;
    assign wr_ok    = ~primary_write_gate_n & second_write_gate_or_load & (cnt != DEPTH);
    assign rd_ok    = ~read_gate_a_n & ~read_gate_b_n & (cnt != 0) & ~ld_lo;
    assign n_thr    = {ofs[1], ofs[0]};
    assign m_thr    = {ofs[3], ofs[2]};
    assign sel_word = {1'b0, ofs[rot]};

    // Word count mirror
    always_ff @(posedge sys_clk_i) begin
        if (dev_rst) cnt <= '0;
        else cnt <= cnt + CW'(wr_ok) - CW'(rd_ok);
    end

    // Mode is whatever the strap showed at the last reset edge
    always_ff @(posedge sys_clk_i) begin
        if (dev_rst) load_mode <= ~second_write_gate_or_load;
    end

    // Offset mirror; a write wins over a read in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (dev_rst) begin
            ofs <= '{`FIFO_OFS_LO_RST, `FIFO_OFS_HI_RST, `FIFO_OFS_LO_RST, `FIFO_OFS_HI_RST};
            rot <= 2'h0;
        end else if (ofs_wr) begin
            ofs[rot] <= data_in[7:0];
            rot      <= rot + 2'h1;
        end else if (ofs_rd) begin
            rot <= rot + 2'h1;
        end
    end

    // =====================================================================
    // Properties
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_empty_level; empty_flag_n == (cnt != 0); endproperty
    property p_full_level; full_flag_n == (cnt != DEPTH); endproperty
    property p_aempty_level; almost_empty_n == (cnt > n_thr[CW-1:0]); endproperty
    property p_afull_level;
        almost_full_n == ((DEPTH - int'(cnt)) > int'(m_thr[CW-1:0]));
    endproperty
    property p_reset_out;
        !reset_n |=> data_out == '0 && !empty_flag_n && !almost_empty_n
                     && full_flag_n && almost_full_n;
    endproperty
    property p_ofs_read; reset_n && ofs_rd && !ofs_wr |=> data_out == $past(sel_word);
    endproperty
    property p_hold_empty;
        reset_n && cnt == 0 && !read_gate_a_n && !read_gate_b_n && !ofs_rd |=> $stable(data_out);
    endproperty
    property p_full_block;
        reset_n && !full_flag_n && !primary_write_gate_n && second_write_gate_or_load && !rd_ok
            |=> !full_flag_n;
    endproperty

    a_empty_level: assert property (p_empty_level) else $error("empty flag wrong");
    a_full_level: assert property (p_full_level) else $error("full flag wrong");
    a_aempty_level: assert property (p_aempty_level) else $error("aempty wrong");
    a_afull_level: assert property (p_afull_level) else $error("afull wrong");
    a_reset_out: assert property (p_reset_out) else $error("reset state wrong");
    a_ofs_read: assert property (p_ofs_read) else $error("offset read wrong");
    a_hold_empty: assert property (p_hold_empty) else $error("empty read moved");
    a_full_block: assert property (p_full_block) else $error("full write taken");

    c_ofs_write: cover property (ofs_wr);
    c_full: cover property (!full_flag_n);
    c_ofs_read: cover property (reset_n && ofs_rd);
endmodule // fifo_pins_asserts

// file: verification/sync_fifo_prog_flags_tb.sv
// Testbench: APB-driven controller joined to the FIFO device
`timescale 1ns/100ps
`include "fifo_map.svh"

module sync_fifo_prog_flags_tb;
    logic        sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, rerr, prog_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [6:0]  wcount;
    int          n_mismatch, n_compared;

    fifo_pins_if pins_bus ();
    fifo_device #(.DEPTH(`FIFO_DEPTH)) i_fifo_device (.sys_clk_i, .rst_i,
        .pins(pins_bus), .word_count_o(wcount), .prog_mode_o(prog_mode));
    fifo_ctrl i_fifo_ctrl (.sys_clk_i, .rst_i, .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pins(pins_bus));
    fifo_pins_asserts #(.DEPTH(`FIFO_DEPTH)) i_fifo_pins_asserts (.sys_clk_i,
        .rst_i, .data_in(pins_bus.data_in), .data_out(pins_bus.data_out),
        .primary_write_gate_n(pins_bus.primary_write_gate_n),
        .second_write_gate_or_load(pins_bus.second_write_gate_or_load),
        .read_gate_a_n(pins_bus.read_gate_a_n), .read_gate_b_n(pins_bus.read_gate_b_n),
        .reset_n(pins_bus.reset_n), .empty_flag_n(pins_bus.empty_flag_n),
        .full_flag_n(pins_bus.full_flag_n), .almost_empty_n(pins_bus.almost_empty_n),
        .almost_full_n(pins_bus.almost_full_n));

    // =====================================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the idle edge first keeps drivers from double assignment
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 50) n_mismatch++;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdat);
    endtask

    // Device acts one edge after the CMD write, RDATA two edges after it
    task automatic cmd(input fifo_pkg::op_t op, input logic [8:0] d);
        apb(1'b1, `CTL_ADDR_CMD, {21'h0, op, d});
        repeat (3) @(posedge sys_clk_i);
    endtask

    function automatic logic [8:0] word(input int i); return 9'(i * 37 + 5); endfunction
    function automatic logic [31:0] fresh(input logic [8:0] d); return {15'h0, 1'b1, 7'h0, d};
    endfunction

    task automatic st(input logic [3:0] e); rd_chk("status", `CTL_ADDR_STATUS, {28'h0, e});
    endtask
    task automatic push(input int a, input int b);
        for (int i = a; i < b; i++) cmd(fifo_pkg::OP_FIFO_WRITE, word(i));
    endtask
    task automatic pop_chk(input fifo_pkg::op_t op, input logic [8:0] d);
        cmd(op, 9'h000);
        rd_chk("rdata", `CTL_ADDR_RDATA, fresh(d));
    endtask
    // Strap is set while reset is held, since it is sampled only then
    task automatic dev_start(input logic strap);
        apb(1'b1, `CTL_ADDR_CTRL, {30'h0, strap, 1'b1});
        apb(1'b1, `CTL_ADDR_CTRL, {30'h0, strap, 1'b0});
        repeat (3) @(posedge sys_clk_i);
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset_regs();
        rd_chk("ctrl", `CTL_ADDR_CTRL, 32'h3);
        st(4'ha);
        rd_chk("unmapped", 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
    endtask

    task automatic t_default_fill();
        dev_start(1'b0);
        chk("mode", 32'h1, {31'h0, prog_mode});
        push(0, 7);  st(4'hb);
        push(7, 8);  st(4'hf);
        push(8, 56); st(4'hf);
        push(56, 57); st(4'h7);
        push(57, 64); st(4'h5);
        chk("count", 32'd64, {25'h0, wcount});
        cmd(fifo_pkg::OP_FIFO_WRITE, 9'h1ff); st(4'h5);
    endtask

    task automatic t_drain();
        for (int i = 0; i < 64; i++) pop_chk(fifo_pkg::OP_FIFO_READ, word(i));
        st(4'ha);
        cmd(fifo_pkg::OP_FIFO_READ, 9'h000);
        apb(1'b0, `CTL_ADDR_RDATA, 32'h0);
        chk("held", {23'h0, word(63)}, {23'h0, rdat[8:0]});
    endtask

    // Partial load, normal traffic, then the rest; upper high bits are dropped
    task automatic t_offsets();
        cmd(fifo_pkg::OP_OFS_WRITE, 9'h003);
        cmd(fifo_pkg::OP_OFS_WRITE, 9'h080);
        cmd(fifo_pkg::OP_FIFO_WRITE, word(100));
        pop_chk(fifo_pkg::OP_FIFO_READ, word(100));
        cmd(fifo_pkg::OP_OFS_WRITE, 9'h005);
        cmd(fifo_pkg::OP_OFS_WRITE, 9'h000);
        pop_chk(fifo_pkg::OP_OFS_READ, 9'h003);
        pop_chk(fifo_pkg::OP_OFS_READ, 9'h080);
        pop_chk(fifo_pkg::OP_OFS_READ, 9'h005);
        pop_chk(fifo_pkg::OP_OFS_READ, 9'h000);
        push(0, 3);   st(4'hb);
        push(3, 4);   st(4'hf);
        push(4, 58);  st(4'hf);
        push(58, 59); st(4'h7);
    endtask

    task automatic t_reload();
        dev_start(1'b0);
        st(4'ha);
        pop_chk(fifo_pkg::OP_OFS_READ, 9'h007);
    endtask

    // Mid-run reset, then two-enable mode
    task automatic t_two_enable();
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        dev_start(1'b1);
        chk("mode", 32'h0, {31'h0, prog_mode});
        cmd(fifo_pkg::OP_OFS_WRITE, 9'h011); st(4'ha);
        cmd(fifo_pkg::OP_FIFO_WRITE, 9'h0aa); st(4'hb);
        pop_chk(fifo_pkg::OP_FIFO_READ, 9'h0aa);
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // =====================================================================
    // Clock, watchdog, main sequence
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Run needs under two thousand cycles
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        n_mismatch++;
        complete_run();
    end

    initial begin
        rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset_regs();
        t_default_fill();
        t_drain();
        t_offsets();
        t_reload();
        t_two_enable();
        complete_run();
    end
endmodule // sync_fifo_prog_flags_tb
